// [hdl/csto_top.sv]
// Our own choice: the plain strobed port.
module csto_top
    import csto_pkg::*;
(
    input wire logic clock, // System clock, 50 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [ADDR_WIDTH-1:0] address, // Register address.
    input wire logic [DATA_WIDTH-1:0] writeData, // Register write data.
    input wire logic writeStrobe, // One-cycle write strobe.
    input wire logic readStrobe, // One-cycle read strobe.
    output logic [DATA_WIDTH-1:0] readData, // Read data, valid the cycle after.
    input wire logic [SENSE_WIDTH-1:0] senseValueA, // New secondary sense A result.
    input wire logic senseValidA, // Pulse: senseValueA is new.
    input wire logic [SENSE_WIDTH-1:0] senseValueB, // New secondary sense B result.
    input wire logic senseValidB, // Pulse: senseValueB is new.
    output logic [6:0] primaryBGainTrim, // Primary sense B gain magnitude.
    output logic primaryBGainNegative, // Primary sense B gain sign.
    output logic [6:0] secondaryAGainTrim, // Secondary sense A gain magnitude.
    output logic secondaryAGainNegative, // Secondary sense A gain sign.
    output logic [6:0] secondaryBGainTrim, // Secondary sense B gain magnitude.
    output logic secondaryBGainNegative, // Secondary sense B gain sign.
    output logic [7:0] secondaryADigitalOffset, // Secondary sense A digital offset.
    output logic [7:0] secondaryBDigitalOffset, // Secondary sense B digital offset.
    output logic [5:0] secondaryAAnalogOffset, // Secondary sense A analog magnitude.
    output logic secondaryAAnalogNegative, // Secondary sense A analog sign.
    output logic [5:0] secondaryBAnalogOffset, // Secondary sense B analog magnitude.
    output logic secondaryBAnalogNegative, // Secondary sense B analog sign.
    output logic overcurrentFlagA, // Overcurrent flag, channel A.
    output logic overcurrentFlagB, // Overcurrent flag, channel B.
    output logic interruptOut // High while an unmasked status bit is set.
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [NUM_GAIN-1:0][7:0] gain;
        logic [NUM_CHANNELS-1:0][7:0] digitalOffset;
        logic [NUM_CHANNELS-1:0][7:0] analogOffset;
        logic [NUM_CHANNELS-1:0][7:0] threshold;
        logic [NUM_CHANNELS-1:0] flagPrev;
        logic [NUM_CHANNELS-1:0] status;
        logic [NUM_CHANNELS-1:0] mask;
        logic [DATA_WIDTH-1:0] readData;
        logic irq;
    } csto_regs_t;

    csto_regs_t regs_reg;
    csto_regs_t regs_next;

    logic [NUM_CHANNELS-1:0] flag;
    logic [NUM_CHANNELS-1:0][SENSE_WIDTH-1:0] value;
    logic [NUM_CHANNELS-1:0][SENSE_WIDTH-1:0] sampleIn;
    logic [NUM_CHANNELS-1:0] sampleValidIn;

    initial begin
        if (DATA_WIDTH < SENSE_WIDTH || DATA_WIDTH < 8) begin
            $error("Data width cannot carry the sense value registers.");
        end
    end

    assign sampleIn = {senseValueB, senseValueA};
    assign sampleValidIn = {senseValidB, senseValidA};

    ////////////////////////////////////////////////////////////////////////////////
    // One comparator per secondary sense channel, each against its own threshold.

    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : gChannel
        csto_cmp_if cmpBus ();
        assign cmpBus.threshold = regs_reg.threshold[ch];
        assign cmpBus.sample = sampleIn[ch];
        assign cmpBus.sampleValid = sampleValidIn[ch];
        assign value[ch] = cmpBus.value;
        assign flag[ch] = cmpBus.flag;
        csto_overcurrent_compare uCompare (
            .clock(clock),
            .reset_n(reset_n),
            .bus(cmpBus.cmp)
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file, read path and interrupt status.

    function automatic logic [DATA_WIDTH-1:0] widen8(input logic [7:0] b);
        widen8 = {{(DATA_WIDTH-8){1'b0}}, b};
    endfunction

    always_comb begin
        regs_next = regs_reg;
        regs_next.readData = '0;
        regs_next.flagPrev = flag;
        if (writeStrobe) begin
            unique case (address)
                ADDR_PRIMARY_B_GAIN: regs_next.gain[0] = writeData[7:0];
                ADDR_SECONDARY_A_GAIN: regs_next.gain[1] = writeData[7:0];
                ADDR_SECONDARY_B_GAIN: regs_next.gain[2] = writeData[7:0];
                ADDR_SECONDARY_A_DIGITAL: regs_next.digitalOffset[0] = writeData[7:0];
                ADDR_SECONDARY_B_DIGITAL: regs_next.digitalOffset[1] = writeData[7:0];
                ADDR_SECONDARY_A_ANALOG: regs_next.analogOffset[0] = writeData[7:0];
                ADDR_SECONDARY_B_ANALOG: regs_next.analogOffset[1] = writeData[7:0];
                ADDR_THRESHOLD_A: regs_next.threshold[0] = writeData[7:0];
                ADDR_THRESHOLD_B: regs_next.threshold[1] = writeData[7:0];
                ADDR_IRQ_MASK: regs_next.mask = writeData[NUM_CHANNELS-1:0];
                ADDR_IRQ_STATUS: regs_next.status = regs_reg.status & ~writeData[NUM_CHANNELS-1:0];
                default: begin
                end
            endcase
        end
        // A flag that rises in the cycle of a clear still sets its status bit.
        regs_next.status = regs_next.status | (flag & ~regs_reg.flagPrev);
        regs_next.irq = |(regs_next.status & regs_next.mask);
        if (readStrobe) begin
            unique case (address)
                ADDR_PRIMARY_B_GAIN: regs_next.readData = widen8(regs_reg.gain[0]);
                ADDR_SECONDARY_A_GAIN: regs_next.readData = widen8(regs_reg.gain[1]);
                ADDR_SECONDARY_B_GAIN: regs_next.readData = widen8(regs_reg.gain[2]);
                ADDR_SECONDARY_A_DIGITAL: regs_next.readData = widen8(regs_reg.digitalOffset[0]);
                ADDR_SECONDARY_B_DIGITAL: regs_next.readData = widen8(regs_reg.digitalOffset[1]);
                ADDR_SECONDARY_A_ANALOG: regs_next.readData = widen8(regs_reg.analogOffset[0]);
                ADDR_SECONDARY_B_ANALOG: regs_next.readData = widen8(regs_reg.analogOffset[1]);
                ADDR_THRESHOLD_A: regs_next.readData = widen8(regs_reg.threshold[0]);
                ADDR_THRESHOLD_B: regs_next.readData = widen8(regs_reg.threshold[1]);
                ADDR_IRQ_STATUS: regs_next.readData = widen8({6'h00, regs_reg.status});
                ADDR_IRQ_MASK: regs_next.readData = widen8({6'h00, regs_reg.mask});
                ADDR_FLAGS: regs_next.readData = widen8({6'h00, flag});
                ADDR_SENSE_VALUE_A: regs_next.readData = DATA_WIDTH'(value[0]);
                ADDR_SENSE_VALUE_B: regs_next.readData = DATA_WIDTH'(value[1]);
                default: regs_next.readData = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            regs_reg <= '0;
            regs_reg.gain <= {NUM_GAIN{GAIN_RESET}};
            regs_reg.digitalOffset <= {NUM_CHANNELS{OFFSET_RESET}};
            regs_reg.analogOffset <= {NUM_CHANNELS{OFFSET_RESET}};
            regs_reg.threshold <= {NUM_CHANNELS{THRESHOLD_RESET}};
        end else begin
            regs_reg <= regs_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trim fields out to the analog front end.

    assign primaryBGainTrim = regs_reg.gain[0][GAIN_MAG_MSB:0];
    assign primaryBGainNegative = regs_reg.gain[0][GAIN_SIGN_BIT];
    assign secondaryAGainTrim = regs_reg.gain[1][GAIN_MAG_MSB:0];
    assign secondaryAGainNegative = regs_reg.gain[1][GAIN_SIGN_BIT];
    assign secondaryBGainTrim = regs_reg.gain[2][GAIN_MAG_MSB:0];
    assign secondaryBGainNegative = regs_reg.gain[2][GAIN_SIGN_BIT];
    assign secondaryADigitalOffset = regs_reg.digitalOffset[0];
    assign secondaryBDigitalOffset = regs_reg.digitalOffset[1];
    assign secondaryAAnalogOffset = regs_reg.analogOffset[0][ANALOG_MAG_MSB:0];
    assign secondaryAAnalogNegative = regs_reg.analogOffset[0][ANALOG_SIGN_BIT];
    assign secondaryBAnalogOffset = regs_reg.analogOffset[1][ANALOG_MAG_MSB:0];
    assign secondaryBAnalogNegative = regs_reg.analogOffset[1][ANALOG_SIGN_BIT];
    assign overcurrentFlagA = flag[0];
    assign overcurrentFlagB = flag[1];
    assign interruptOut = regs_reg.irq;
    assign readData = regs_reg.readData;

endmodule

// [hdl/csto_pkg.sv]
package csto_pkg;

    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 16;
    localparam int SENSE_WIDTH = 16;
    localparam int NUM_CHANNELS = 2;
    localparam int NUM_GAIN = 3;

    localparam logic [15:0] ADDR_PRIMARY_B_GAIN = 16'hFE11;
    localparam logic [15:0] ADDR_SECONDARY_A_GAIN = 16'hFE12;
    localparam logic [15:0] ADDR_SECONDARY_B_GAIN = 16'hFE13;
    localparam logic [15:0] ADDR_SECONDARY_A_DIGITAL = 16'hFE14;
    localparam logic [15:0] ADDR_SECONDARY_B_DIGITAL = 16'hFE15;
    localparam logic [15:0] ADDR_SECONDARY_A_ANALOG = 16'hFE16;
    localparam logic [15:0] ADDR_SECONDARY_B_ANALOG = 16'hFE17;
    localparam logic [15:0] ADDR_THRESHOLD_A = 16'hFE18;
    localparam logic [15:0] ADDR_THRESHOLD_B = 16'hFE19;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFE20;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hFE21;
    localparam logic [15:0] ADDR_FLAGS = 16'hFE22;
    localparam logic [15:0] ADDR_SENSE_VALUE_A = 16'hFED3;
    localparam logic [15:0] ADDR_SENSE_VALUE_B = 16'hFED4;

    localparam int GAIN_SIGN_BIT = 7;
    localparam int GAIN_MAG_MSB = 6;
    localparam int ANALOG_SIGN_BIT = 6;
    localparam int ANALOG_MAG_MSB = 5;

    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'hFF;
    localparam logic [7:0] THRESHOLD_DISABLED = 8'hFF;
    localparam logic [7:0] THRESHOLD_MIN_CODE = 8'h02;
    localparam logic [7:0] THRESHOLD_MAX_CODE = 8'hF1;

    // Threshold step in nanovolts; trip level is (code + 1) times this step.
    localparam int SENSE_FULL_SCALE_UV = 120000;
    localparam int SENSE_STEPS = 4096;
    localparam int THRESHOLD_STEP_NV = 468800;

endpackage

// [hdl/csto_cmp_if.sv]
interface csto_cmp_if;
    import csto_pkg::*;
    logic [7:0] threshold;
    logic [SENSE_WIDTH-1:0] sample;
    logic sampleValid;
    logic [SENSE_WIDTH-1:0] value;
    logic flag;
    modport ctrl (output threshold, output sample, output sampleValid, input value, input flag);
    modport cmp (input threshold, input sample, input sampleValid, output value, output flag);
endinterface

// [hdl/csto_ocp_compare.sv]
module csto_overcurrent_compare
    import csto_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    csto_cmp_if.cmp bus // Threshold, sample and flag of one channel.
);

    typedef struct packed {
        logic [SENSE_WIDTH-1:0] value;
        logic flag;
    } csto_cmp_state_t;

    csto_cmp_state_t state_reg;
    csto_cmp_state_t state_next;

    initial begin
        if (SENSE_WIDTH < 9) begin
            $error("Sense width too narrow for an 8-bit upper byte compare.");
        end
    end

    always_comb begin
        state_next = state_reg;
        if (bus.sampleValid) begin
            state_next.value = bus.sample;
            state_next.flag = bus.sample[SENSE_WIDTH-1 -: 8] > bus.threshold;
        end
        if (bus.threshold == THRESHOLD_DISABLED) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.value = state_reg.value;
    assign bus.flag = state_reg.flag;

endmodule

// [bench/csto_top_monitor.sv]
module csto_monitor
    import csto_pkg::*;
(
    input wire logic clock, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic [ADDR_WIDTH-1:0] address, // Address.
    input wire logic [DATA_WIDTH-1:0] writeData, // Write data.
    input wire logic writeStrobe, // Write.
    input wire logic readStrobe, // Read.
    input wire logic [DATA_WIDTH-1:0] readData, // Read data.
    input wire logic [SENSE_WIDTH-1:0] senseValueA, // Sense A.
    input wire logic senseValidA, // Sense A new.
    input wire logic [SENSE_WIDTH-1:0] senseValueB, // Sense B.
    input wire logic senseValidB, // Sense B new.
    input wire logic [6:0] primaryBGainTrim, // Gain.
    input wire logic primaryBGainNegative, // Gain sign.
    input wire logic [5:0] secondaryAAnalogOffset, // Analog.
    input wire logic secondaryAAnalogNegative, // Analog sign.
    input wire logic overcurrentFlagA, // Flag A.
    input wire logic overcurrentFlagB, // Flag B.
    input wire logic interruptOut // Interrupt.
);
    logic [7:0] thrAReg;
    logic [7:0] thrBReg;
    logic maskAReg;
    // Shadow copies of the thresholds and of mask bit 0 (channel A), taken from the bus.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            thrAReg <= 8'hFF;
            thrBReg <= 8'hFF;
            maskAReg <= 1'b0;
        end else if (writeStrobe) begin
            if (address == ADDR_THRESHOLD_A) thrAReg <= writeData[7:0];
            if (address == ADDR_THRESHOLD_B) thrBReg <= writeData[7:0];
            if (address == ADDR_IRQ_MASK) maskAReg <= writeData[0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    flag_a_compare_a: assert property (senseValidA |=> overcurrentFlagA ==
        ($past(senseValueA[15:8]) > $past(thrAReg) && $past(thrAReg) != 8'hFF))
        else $error("Flag A wrong after sample.");
    flag_b_compare_a: assert property (senseValidB |=> overcurrentFlagB ==
        ($past(senseValueB[15:8]) > $past(thrBReg) && $past(thrBReg) != 8'hFF))
        else $error("Flag B wrong after sample.");
    flag_off_a: assert property (thrAReg == 8'hFF |=> !overcurrentFlagA)
        else $error("Flag A set while disabled.");
    flag_hold_a: assert property (!senseValidA && thrAReg != 8'hFF |=>
        $stable(overcurrentFlagA)) else $error("Flag A moved without sample.");
    read_idle_a: assert property (!readStrobe |=> readData == 16'h0000)
        else $error("Read data not zero when idle.");
    read_thr_a: assert property (readStrobe && address == ADDR_THRESHOLD_A |=>
        readData == {8'h00, $past(thrAReg)}) else $error("Threshold A readback wrong.");
    gain_field_a: assert property (writeStrobe && address == ADDR_PRIMARY_B_GAIN |=>
        {primaryBGainNegative, primaryBGainTrim} == $past(writeData[7:0]))
        else $error("Gain fields wrong after write.");
    analog_field_a: assert property (writeStrobe && address == ADDR_SECONDARY_A_ANALOG |=>
        {secondaryAAnalogNegative, secondaryAAnalogOffset} == $past(writeData[6:0]))
        else $error("Analog fields wrong after write.");
    irq_raise_a: assert property ($rose(overcurrentFlagA) && maskAReg |-> ##[1:2] interruptOut)
        else $error("Interrupt missing after flag A.");
endmodule

bind csto_top csto_monitor mon (.clock(clock), .reset_n(reset_n), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .senseValueA(senseValueA), .senseValidA(senseValidA),
    .senseValueB(senseValueB), .senseValidB(senseValidB),
    .primaryBGainTrim(primaryBGainTrim), .primaryBGainNegative(primaryBGainNegative),
    .secondaryAAnalogOffset(secondaryAAnalogOffset),
    .secondaryAAnalogNegative(secondaryAAnalogNegative),
    .overcurrentFlagA(overcurrentFlagA), .overcurrentFlagB(overcurrentFlagB),
    .interruptOut(interruptOut));

// [bench/csto_top_tb.sv]
module csto_top_tb;
    import csto_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] addr; logic [15:0] data; logic [15:0] want;} csto_row_t;
    logic clock, reset_n, writeStrobe, readStrobe, senseValidA, senseValidB;
    logic [15:0] address, writeData, readData, senseValueA, senseValueB;
    logic overcurrentFlagA, overcurrentFlagB, interruptOut;
    logic [6:0] primaryBGainTrim, secondaryAGainTrim, secondaryBGainTrim;
    logic primaryBGainNegative, secondaryAGainNegative, secondaryBGainNegative;
    logic [7:0] secondaryADigitalOffset, secondaryBDigitalOffset;
    logic [5:0] secondaryAAnalogOffset, secondaryBAnalogOffset;
    logic secondaryAAnalogNegative, secondaryBAnalogNegative;
    int badCount = 0;
    int checkCount = 0;
    int cycles = 0;
    csto_row_t rows [10] = '{'{16'hFE11, 16'h00D5, 16'h00D5}, '{16'hFE12, 16'h12FF, 16'h00FF},
        '{16'hFE13, 16'h0001, 16'h0001}, '{16'hFE14, 16'h00A5, 16'h00A5},
        '{16'hFE15, 16'h005A, 16'h005A}, '{16'hFE16, 16'h00C1, 16'h00C1},
        '{16'hFE17, 16'h0040, 16'h0040}, '{16'hFE18, 16'h0002, 16'h0002},
        '{16'hFE19, 16'h00F1, 16'h00F1}, '{16'hFE00, 16'h0055, 16'h0000}};
    csto_top dut (.clock(clock), .reset_n(reset_n), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .senseValueA(senseValueA), .senseValidA(senseValidA), .senseValueB(senseValueB),
        .senseValidB(senseValidB), .primaryBGainTrim(primaryBGainTrim),
        .primaryBGainNegative(primaryBGainNegative), .secondaryAGainTrim(secondaryAGainTrim),
        .secondaryAGainNegative(secondaryAGainNegative), .secondaryBGainTrim(secondaryBGainTrim),
        .secondaryBGainNegative(secondaryBGainNegative),
        .secondaryADigitalOffset(secondaryADigitalOffset),
        .secondaryBDigitalOffset(secondaryBDigitalOffset),
        .secondaryAAnalogOffset(secondaryAAnalogOffset),
        .secondaryAAnalogNegative(secondaryAAnalogNegative),
        .secondaryBAnalogOffset(secondaryBAnalogOffset),
        .secondaryBAnalogNegative(secondaryBAnalogNegative), .overcurrentFlagA(overcurrentFlagA),
        .overcurrentFlagB(overcurrentFlagB), .interruptOut(interruptOut));
    ////////////////////////////////////////
    task automatic reportAndStop();
        $display("Checks %0d, mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk16(input string name, input logic [15:0] want, input logic [15:0] seen);
        checkCount++;
        if (seen !== want) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic chk1(input string name, input logic want, input logic seen);
        checkCount++;
        if (seen !== want) begin
            badCount++;
            $display("MISMATCH %s expected %b seen %b", name, want, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] want);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        chk16("readData", want, readData);
    endtask
    // Drives one sample on the chosen channel and lets the flag settle.
    task automatic sense(input bit chB, input logic [15:0] v);
        @(posedge clock);
        senseValueA <= v;
        senseValueB <= v;
        senseValidA <= !chB;
        senseValidB <= chB;
        @(posedge clock);
        senseValidA <= 1'b0;
        senseValidB <= 1'b0;
        #1;
    endtask
    task automatic resetDut();
        reset_n <= 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
    endtask
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        forever begin
            @(posedge clock);
            cycles++;
            if (cycles == 2000) begin
                badCount++;
                reportAndStop();
            end
        end
    end
    initial begin
        {writeStrobe, readStrobe, senseValidA, senseValidB} <= 4'h0;
        {address, writeData, senseValueA, senseValueB} <= 64'h0;
        resetDut();
        rd(16'hFE18, 16'h00FF);
        rd(16'hFE14, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr, rows[i].want);
        end
        chk16("primaryBGain", 16'h00D5, {8'h00, primaryBGainNegative, primaryBGainTrim});
        chk16("secondaryAGain", 16'h00FF, {8'h00, secondaryAGainNegative, secondaryAGainTrim});
        chk16("secondaryBGain", 16'h0001, {8'h00, secondaryBGainNegative, secondaryBGainTrim});
        chk16("secondaryADigitalOffset", 16'h00A5, {8'h00, secondaryADigitalOffset});
        chk16("secondaryBDigitalOffset", 16'h005A, {8'h00, secondaryBDigitalOffset});
        chk16("secondaryAAnalog", 16'h0041,
            {9'h000, secondaryAAnalogNegative, secondaryAAnalogOffset});
        chk16("secondaryBAnalog", 16'h0040,
            {9'h000, secondaryBAnalogNegative, secondaryBAnalogOffset});
        wr(16'hFE21, 16'h0001);
        rd(16'hFE21, 16'h0001);
        sense(0, 16'h0300);
        chk1("overcurrentFlagA", 1'b1, overcurrentFlagA);
        sense(0, 16'h02FF);
        chk1("overcurrentFlagA", 1'b0, overcurrentFlagA);
        sense(1, 16'hF200);
        chk1("overcurrentFlagB", 1'b1, overcurrentFlagB);
        chk1("overcurrentFlagA", 1'b0, overcurrentFlagA);
        chk1("interruptOut", 1'b1, interruptOut);
        rd(16'hFE22, 16'h0002);
        rd(16'hFED4, 16'hF200);
        rd(16'hFE20, 16'h0003);
        wr(16'hFE20, 16'h0001);
        repeat (2) @(posedge clock);
        #1;
        chk1("interruptOut", 1'b0, interruptOut);
        rd(16'hFE20, 16'h0002);
        sense(0, 16'h0300);
        wr(16'hFE18, 16'h00FF);
        repeat (2) @(posedge clock);
        #1;
        chk1("overcurrentFlagA", 1'b0, overcurrentFlagA);
        sense(0, 16'hFFFF);
        chk1("overcurrentFlagA", 1'b0, overcurrentFlagA);
        rd(16'hFED3, 16'hFFFF);
        @(posedge clock);
        resetDut();
        rd(16'hFE19, 16'h00FF);
        chk1("overcurrentFlagB", 1'b0, overcurrentFlagB);
        reportAndStop();
    end
endmodule
